// [tid_pkg.sv]
package tid_pkg;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam int IR_W = 3;
    localparam int ID_W = 32;

    typedef logic [IR_W-1:0] tid_ir_t;

    localparam tid_ir_t IR_EXTEST     = 3'h0;
    localparam tid_ir_t IR_IDCODE     = 3'h1;
    localparam tid_ir_t IR_SAMPLE_Z   = 3'h2;
    localparam tid_ir_t IR_RSVD_A     = 3'h3;
    localparam tid_ir_t IR_SAMPLE_PRE = 3'h4;
    localparam tid_ir_t IR_PRIVATE    = 3'h5;
    localparam tid_ir_t IR_RSVD_B     = 3'h6;
    localparam tid_ir_t IR_BYPASS     = 3'h7;

    localparam tid_ir_t    IR_RESET       = IR_IDCODE;
    localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;
    localparam logic       IR_CAPTURE_MSB = 1'h0;
    localparam logic       BYP_CAPTURE    = 1'h0;

    // identification word; value is arbitrary
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0A5C_3001;

    // ------------------------------------------------------------
    // tap controller states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_TLR        = 16'h0001,
        ST_IDLE       = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAPTURE_DR = 16'h0008,
        ST_SHIFT_DR   = 16'h0010,
        ST_EXIT1_DR   = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EXIT2_DR   = 16'h0080,
        ST_UPDATE_DR  = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAPTURE_IR = 16'h0400,
        ST_SHIFT_IR   = 16'h0800,
        ST_EXIT1_IR   = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EXIT2_IR   = 16'h4000,
        ST_UPDATE_IR  = 16'h8000
    } tid_state_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tid_pins_t;

    typedef struct packed {
        logic sel_bsr;
        logic sel_id;
        logic sel_byp;
        logic ring_capture;
        logic force_hiz;
        logic drive_pins;
    } tid_dec_t;

    function automatic tid_dec_t tid_decode(input tid_ir_t ir);
        tid_dec_t d;
        d = '0;
        case (ir)
            IR_EXTEST:
            begin
                d.sel_bsr      = 1'b1;
                d.ring_capture = 1'b1;
                d.drive_pins   = 1'b1;
            end
            IR_IDCODE:
            begin
                d.sel_id = 1'b1;
            end
            IR_SAMPLE_Z:
            begin
                d.sel_bsr      = 1'b1;
                d.ring_capture = 1'b1;
                d.force_hiz    = 1'b1;
            end
            IR_SAMPLE_PRE:
            begin
                d.sel_bsr      = 1'b1;
                d.ring_capture = 1'b1;
            end
            // reserved, private and bypass codes all take the bypass path
            default:
            begin
                d.sel_byp = 1'b1;
            end
        endcase
        return d;
    endfunction : tid_decode

endpackage : tid_pkg

// [tid_sync.sv]
`timescale 1ns/1ps

module tid_sync (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire tid_pkg::tid_pins_t pins_in,
    output tid_pkg::tid_pins_t      pins_out
);
    import tid_pkg::*;

    localparam int W = $bits(tid_pins_t);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] f_q;
    logic [W-1:0] f_d;

    // ------------------------------------------------------------
    // filter: a change counts once stages two and three agree
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_comb
            begin
                f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            f_q  <= '0;
        end
        else
        begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q  <= f_d;
        end
    end

    assign pins_out = f_q;

endmodule : tid_sync

// [tid_decoder.sv]
`timescale 1ns/1ps

module tid_decoder (
    input  wire logic           CLOCK,
    input  wire logic           RST_N,
    input  wire logic           TCK,
    input  wire logic           TMS,
    input  wire logic           TDI,
    input  wire logic           BSR_SO,
    output logic                TDO,
    output logic                TDO_OE,
    output logic                RAM_HIZ,
    output logic                EXTEST_DRIVE,
    output logic                BSR_CAPTURE,
    output logic                BSR_SHIFT,
    output logic                BSR_UPDATE,
    output logic                BSR_SI,
    output tid_pkg::tid_ir_t    INSTR
);
    import tid_pkg::*;

    tid_pins_t           pins_raw;
    tid_pins_t           pins_f;
    logic                tck_prev_q;
    logic                tck_rise;
    logic                tck_fall;

    tid_state_t          state_q;
    tid_state_t          state_d;
    tid_ir_t             ir_q;
    tid_ir_t             ir_d;
    tid_ir_t             ir_sr_q;
    tid_ir_t             ir_sr_d;
    logic [ID_W-1:0]     id_sr_q;
    logic [ID_W-1:0]     id_sr_d;
    logic                byp_q;
    logic                byp_d;
    logic                tdo_q;
    logic                tdo_d;
    logic                oe_q;
    logic                oe_d;
    logic                hiz_q;
    logic                hiz_d;
    logic                drv_q;
    logic                drv_d;
    logic                bcap_q;
    logic                bcap_d;
    logic                bsh_q;
    logic                bsh_d;
    logic                bup_q;
    logic                bup_d;
    logic                bsi_q;
    logic                bsi_d;
    tid_dec_t            dec;

    // ------------------------------------------------------------
    // pin sampling and tck edges
    // ------------------------------------------------------------
    // tck is asynchronous to the ram clock, so every pin is filtered
    assign pins_raw = '{tck: TCK, tms: TMS, tdi: TDI};

    tid_sync u_sync (
        .clk      (CLOCK),
        .rst_n    (RST_N),
        .pins_in  (pins_raw),
        .pins_out (pins_f)
    );

    assign tck_rise = pins_f.tck & ~tck_prev_q;
    assign tck_fall = ~pins_f.tck & tck_prev_q;
    assign dec      = tid_decode(ir_q);

    // ------------------------------------------------------------
    // tap controller
    // ------------------------------------------------------------
    function automatic tid_state_t tid_next(input tid_state_t s, input logic tms);
        tid_state_t n;
        n = ST_TLR;
        case (s)
            ST_TLR:        n = tms ? ST_TLR      : ST_IDLE;
            ST_IDLE:       n = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:     n = tms ? ST_SEL_IR   : ST_CAPTURE_DR;
            ST_CAPTURE_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR:   n = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
            ST_PAUSE_DR:   n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR:   n = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
            ST_UPDATE_DR:  n = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:     n = tms ? ST_TLR      : ST_CAPTURE_IR;
            ST_CAPTURE_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR:   n = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
            ST_PAUSE_IR:   n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR:   n = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
            ST_UPDATE_IR:  n = tms ? ST_SEL_DR   : ST_IDLE;
            default:       n = ST_TLR;
        endcase
        return n;
    endfunction : tid_next

    always_comb
    begin
        state_d = state_q;
        ir_d    = ir_q;
        ir_sr_d = ir_sr_q;
        id_sr_d = id_sr_q;
        byp_d   = byp_q;
        tdo_d   = tdo_q;
        oe_d    = oe_q;
        bcap_d  = 1'b0;
        bsh_d   = 1'b0;
        bup_d   = 1'b0;
        bsi_d   = bsi_q;
        hiz_d   = dec.force_hiz;
        drv_d   = dec.drive_pins;
        if (tck_rise)
        begin
            state_d = tid_next(state_q, pins_f.tms);
            case (state_q)
                ST_TLR:
                begin
                    ir_d = IR_RESET;
                end
                ST_CAPTURE_IR:
                begin
                    ir_sr_d = {IR_CAPTURE_MSB, IR_CAPTURE_LSB};
                end
                ST_SHIFT_IR:
                begin
                    ir_sr_d = {pins_f.tdi, ir_sr_q[IR_W-1:1]};
                end
                ST_CAPTURE_DR:
                begin
                    if (dec.sel_id)
                    begin
                        id_sr_d = ID_VALUE;
                    end
                    byp_d  = BYP_CAPTURE;
                    bcap_d = dec.ring_capture;
                end
                ST_SHIFT_DR:
                begin
                    id_sr_d = {pins_f.tdi, id_sr_q[ID_W-1:1]};
                    byp_d   = pins_f.tdi;
                    bsh_d   = dec.sel_bsr;
                    bsi_d   = pins_f.tdi;
                end
                default:
                begin
                end
            endcase
            // new code takes effect only on entry to update-ir
            if (state_d == ST_UPDATE_IR)
            begin
                ir_d = ir_sr_q;
            end
            if (state_d == ST_UPDATE_DR)
            begin
                bup_d = dec.sel_bsr;
            end
        end
        // tdo changes on the falling edge, lsb first
        if (tck_fall)
        begin
            oe_d = (state_q == ST_SHIFT_DR) || (state_q == ST_SHIFT_IR);
            if (state_q == ST_SHIFT_IR)
            begin
                tdo_d = ir_sr_q[0];
            end
            else if (dec.sel_id)
            begin
                tdo_d = id_sr_q[0];
            end
            else if (dec.sel_bsr)
            begin
                tdo_d = BSR_SO;
            end
            else
            begin
                tdo_d = byp_q;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tck_prev_q <= 1'b0;
            state_q    <= ST_TLR;
            ir_q       <= IR_RESET;
            ir_sr_q    <= IR_RESET;
            id_sr_q    <= '0;
            byp_q      <= 1'b0;
            tdo_q      <= 1'b0;
            oe_q       <= 1'b0;
            hiz_q      <= 1'b0;
            drv_q      <= 1'b0;
            bcap_q     <= 1'b0;
            bsh_q      <= 1'b0;
            bup_q      <= 1'b0;
            bsi_q      <= 1'b0;
        end
        else
        begin
            tck_prev_q <= pins_f.tck;
            state_q    <= state_d;
            ir_q       <= ir_d;
            ir_sr_q    <= ir_sr_d;
            id_sr_q    <= id_sr_d;
            byp_q      <= byp_d;
            tdo_q      <= tdo_d;
            oe_q       <= oe_d;
            hiz_q      <= hiz_d;
            drv_q      <= drv_d;
            bcap_q     <= bcap_d;
            bsh_q      <= bsh_d;
            bup_q      <= bup_d;
            bsi_q      <= bsi_d;
        end
    end

    assign TDO          = tdo_q;
    assign TDO_OE       = oe_q;
    assign RAM_HIZ      = hiz_q;
    assign EXTEST_DRIVE = drv_q;
    assign BSR_CAPTURE  = bcap_q;
    assign BSR_SHIFT    = bsh_q;
    assign BSR_UPDATE   = bup_q;
    assign BSR_SI       = bsi_q;
    assign INSTR        = ir_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    tlr_default_a: assert property (tck_rise && state_q == ST_TLR |=> ir_q == IR_IDCODE)
        else $error("tlr did not load idcode");
    reset_default_a: assert property ($rose(RST_N) |-> ir_q == IR_IDCODE)
        else $error("default instruction is not idcode");
    cap_ir_a: assert property (tck_rise && state_q == ST_CAPTURE_IR |=> ir_sr_q[1:0] == IR_CAPTURE_LSB)
        else $error("capture-ir did not load 01");
    ir_hold_a: assert property (!(tck_rise && (state_q == ST_TLR
        || tid_next(state_q, pins_f.tms) == ST_UPDATE_IR)) |=> $stable(ir_q))
        else $error("instruction changed outside update-ir");
    hiz_sel_a: assert property ((ir_q == IR_SAMPLE_Z) [*2] |-> RAM_HIZ)
        else $error("sample-z without high-z");
    id_cap_a: assert property (tck_rise && state_q == ST_CAPTURE_DR && ir_q == IR_IDCODE
        |=> id_sr_q == ID_VALUE)
        else $error("id register not captured");
    id_first_a: assert property (tck_fall && state_q == ST_SHIFT_DR && ir_q == IR_IDCODE
        |=> TDO == $past(id_sr_q[0]) && TDO_OE)
        else $error("id lsb not first at tdo");
    byp_path_a: assert property (tck_fall && state_q == ST_SHIFT_DR
        && (ir_q == IR_RSVD_A || ir_q == IR_RSVD_B || ir_q == IR_PRIVATE || ir_q == IR_BYPASS)
        |=> TDO == $past(byp_q))
        else $error("bypass path not selected");
    bsr_path_a: assert property (tck_fall && state_q == ST_SHIFT_DR
        && (ir_q == IR_EXTEST || ir_q == IR_SAMPLE_Z || ir_q == IR_SAMPLE_PRE)
        |=> TDO == $past(BSR_SO))
        else $error("boundary path not selected");
    ring_cap_a: assert property (tck_rise && state_q == ST_CAPTURE_DR && ir_q[1:0] == 2'h0
        |=> BSR_CAPTURE ##1 !BSR_CAPTURE)
        else $error("io ring not captured once");

    idcode_shift_c: cover property (tck_fall && state_q == ST_SHIFT_DR && ir_q == IR_IDCODE);
    bypass_shift_c: cover property (tck_fall && state_q == ST_SHIFT_DR && ir_q == IR_BYPASS);
    samplez_c:      cover property (RAM_HIZ && BSR_CAPTURE);
    update_ir_c:    cover property (tck_rise && state_q == ST_EXIT1_IR && pins_f.tms);

endmodule : tid_decoder

// [tid_ctrl_model.sv]
`timescale 1ns/1ps

module tid_ctrl_model (
    input  wire logic clk,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);

    // ------------------------------------------------------------
    // idle levels: test clock parked low, data lines pulled high
    // ------------------------------------------------------------
    initial
    begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
    end

    // ------------------------------------------------------------
    // one test clock: 4 system clocks low, 4 high (200 ns)
    // ------------------------------------------------------------
    // tdo is read late in the high phase, since the decoder answers
    // about five system clocks after a fall
    task automatic tick(input logic m, input logic d, output logic q);
        @(negedge clk);
        tms = m;
        tdi = d;
        repeat (3) @(negedge clk);
        tck = 1'h1;
        repeat (4) @(negedge clk);
        q   = tdo;
        tck = 1'h0;
    endtask : tick

    // tdi is a don't-care here, so it toggles rather than holding
    task automatic walk(input logic m);
        logic q;
        tick(m, ~tdi, q);
    endtask : walk

    task automatic reset_tap;
        repeat (5) walk(1'h1);
        walk(1'h0);
    endtask : reset_tap

    // from idle through capture and shift, then update and back to idle
    task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        walk(1'h1);
        if (is_ir)
            walk(1'h1);
        walk(1'h0);
        walk(1'h0);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        walk(1'h1);
        walk(1'h0);
        tdi = 1'h1;
    endtask : scan

endmodule : tid_ctrl_model

// [test_tap_instruction_decoder.sv]
`timescale 1ns/1ps

module test_tap_instruction_decoder;
    import tid_pkg::*;

    typedef struct {
        tid_ir_t     code;
        logic        hiz;
        logic        drv;
        logic        cap;
        int          n;
        logic [31:0] exp;
    } tid_row_t;

    logic        clock;
    logic        rst_n;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        bsr_so;
    logic        tdo;
    logic        tdo_oe;
    logic        ram_hiz;
    logic        extest_drive;
    logic        bsr_capture;
    logic        bsr_shift;
    logic        bsr_update;
    logic        bsr_si;
    tid_ir_t     instr;
    logic [7:0]  bsr;
    int          errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          caps;
    int          upds;
    tid_row_t    rows [8];

    tid_decoder DUT (
        .CLOCK        (clock),
        .RST_N        (rst_n),
        .TCK          (tck),
        .TMS          (tms),
        .TDI          (tdi),
        .BSR_SO       (bsr_so),
        .TDO          (tdo),
        .TDO_OE       (tdo_oe),
        .RAM_HIZ      (ram_hiz),
        .EXTEST_DRIVE (extest_drive),
        .BSR_CAPTURE  (bsr_capture),
        .BSR_SHIFT    (bsr_shift),
        .BSR_UPDATE   (bsr_update),
        .BSR_SI       (bsr_si),
        .INSTR        (instr)
    );

    tid_ctrl_model ctrl (
        .clk (clock),
        .tdo (tdo),
        .tck (tck),
        .tms (tms),
        .tdi (tdi)
    );

    initial
    begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // boundary register stand-in, 8 bits, lsb leaves first
    // ------------------------------------------------------------
    always @(negedge clock)
    begin
        if (!rst_n)
        begin
            bsr  <= 8'h00;
            caps <= 0;
            upds <= 0;
        end
        else
        begin
            if (bsr_capture)
                bsr <= 8'hC5;
            else if (bsr_shift)
                bsr <= {bsr_si, bsr[7:1]};
            caps <= caps + int'(bsr_capture);
            upds <= upds + int'(bsr_update);
        end
    end
    assign bsr_so = bsr[0];

    // whole run is near 2300 clocks; the ceiling leaves ample margin
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    task automatic load_ir(input tid_ir_t code);
        logic [31:0] d;
        ctrl.scan(1'h1, 3, {29'h0, code}, d);
        check("ir capture", d, 32'h0000_0001);
    endtask : load_ir

    initial
    begin
        logic [31:0] d;
        logic        q;
        int          c0;
        int          u0;
        rst_n = 1'h0;
        rows = '{
            '{IR_EXTEST,     1'h0, 1'h1, 1'h1, 8,  32'h0000_00C5},
            '{IR_IDCODE,     1'h0, 1'h0, 1'h0, 32, ID_VALUE},
            '{IR_SAMPLE_Z,   1'h1, 1'h0, 1'h1, 8,  32'h0000_00C5},
            '{IR_RSVD_A,     1'h0, 1'h0, 1'h0, 2,  32'h0000_0002},
            '{IR_SAMPLE_PRE, 1'h0, 1'h0, 1'h1, 8,  32'h0000_00C5},
            '{IR_PRIVATE,    1'h0, 1'h0, 1'h0, 2,  32'h0000_0002},
            '{IR_RSVD_B,     1'h0, 1'h0, 1'h0, 2,  32'h0000_0002},
            '{IR_BYPASS,     1'h0, 1'h0, 1'h0, 2,  32'h0000_0002}
        };
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst_n = 1'h1;
        repeat (8) @(negedge clock);
        check("instr after reset", instr, IR_IDCODE);
        check("oe after reset", tdo_oe, 1'h0);
        // reset leaves the tap in test-logic-reset; scans start from idle
        ctrl.walk(1'h0);
        ctrl.scan(1'h0, 32, 32'h0000_0001, d);
        check("default id word", d, ID_VALUE);
        foreach (rows[i])
        begin
            c0 = caps;
            u0 = upds;
            load_ir(rows[i].code);
            check("instr", instr, rows[i].code);
            check("ram hiz", ram_hiz, rows[i].hiz);
            check("extest drive", extest_drive, rows[i].drv);
            ctrl.scan(1'h0, rows[i].n, 32'h0000_0001, d);
            check("dr out", d, rows[i].exp);
            if (rows[i].cap)
                check("bsr shifted in", bsr, 32'h0000_0001);
            check("captures", caps - c0, rows[i].cap);
            check("updates", upds - u0, rows[i].cap);
            check("oe idle", tdo_oe, 1'h0);
        end
        // new code must wait for update, so stop in exit1 and look
        ctrl.walk(1'h1);
        ctrl.walk(1'h1);
        ctrl.walk(1'h0);
        ctrl.walk(1'h0);
        ctrl.tick(1'h0, 1'h0, q);
        check("oe in shift", tdo_oe, 1'h1);
        ctrl.tick(1'h0, 1'h0, q);
        ctrl.tick(1'h1, 1'h0, q);
        repeat (8) @(negedge clock);
        check("instr before update", instr, IR_BYPASS);
        ctrl.walk(1'h1);
        ctrl.walk(1'h0);
        check("instr after update", instr, IR_EXTEST);
        ctrl.reset_tap();
        check("instr after tlr", instr, IR_IDCODE);
        check("drive after tlr", extest_drive, 1'h0);
        load_ir(IR_SAMPLE_Z);
        check("hiz set", ram_hiz, 1'h1);
        rst_n = 1'h0;
        repeat (2) @(negedge clock);
        check("instr in reset", instr, IR_IDCODE);
        check("hiz in reset", ram_hiz, 1'h0);
        rst_n = 1'h1;
        repeat (8) @(negedge clock);
        ctrl.walk(1'h0);
        ctrl.scan(1'h0, 32, 32'h0000_0001, d);
        check("id after reset", d, ID_VALUE);
        finish_test();
    end

endmodule : test_tap_instruction_decoder
